// file: core_addr_pkg.sv
// Constants, types and field layout for the core addressing block
package core_addr_pkg;
   localparam int PC_W = 15;
   localparam int PM_W = 14;
   localparam int DADDR_W = 12;
   localparam int STACK_DEPTH = 16;
   localparam int BANKS = 32;
   localparam int BANK_BYTES = 128;
   localparam logic [4:0] STACK_FULL = 5'h10;
   localparam logic [14:0] RESET_VECTOR = 15'h0000;
   localparam logic [14:0] IRQ_VECTOR = 15'h0004;
   localparam logic [14:0] PM_LAST_SMALL = 15'h1FFF;
   localparam logic [14:0] PM_LAST_LARGE = 15'h3FFF;
   localparam int PTR_PM_BIT = 15;
   localparam logic [6:0] OFS_INDIRECT_DATA_PORT_0 = 7'h00;
   localparam logic [6:0] OFS_INDIRECT_DATA_PORT_1 = 7'h01;
   localparam logic [6:0] OFS_PCL = 7'h02;
   localparam logic [6:0] OFS_STATUS = 7'h03;
   localparam logic [6:0] OFS_PTR0_LO = 7'h04;
   localparam logic [6:0] OFS_PTR0_HI = 7'h05;
   localparam logic [6:0] OFS_PTR1_LO = 7'h06;
   localparam logic [6:0] OFS_PTR1_HI = 7'h07;
   localparam logic [6:0] OFS_BSR = 7'h08;
   localparam logic [6:0] OFS_WORKING_ACCUMULATOR = 7'h09;
   localparam logic [6:0] OFS_COUNTER_UPPER_LATCH = 7'h0A;
   localparam logic [6:0] OFS_INTERRUPT_CONTROL = 7'h0B;
   localparam int ST_TO = 4;
   localparam int ST_PD = 3;
   localparam int ST_Z = 2;
   localparam int ST_DC = 1;
   localparam int ST_C = 0;
   localparam logic [7:0] CORE_RST = 8'h00;
   localparam logic [2:0] STATUS_PAD = 3'h0;

   typedef enum logic [2:0] {alu_add, alu_sub, alu_logic, alu_rot_left, alu_rot_right} alu_op_t;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [6:0] ofs;
      logic [7:0] wdata;
   } file_req_t;

   typedef struct packed {
      logic go;
      alu_op_t op;
      logic [7:0] a;
      logic [7:0] b;
   } alu_req_t;

   typedef struct packed {
      logic re;
      logic we;
      logic [11:0] addr;
      logic [7:0] wdata;
   } ram_req_t;

   typedef struct packed {
      logic [7:0] res;
      logic z;
      logic dc;
      logic c;
      logic mz;
      logic mdc;
      logic mc;
   } alu_out_t;
endpackage : core_addr_pkg

// file: cpu_core_memory_addressing.sv
// Program counter, return stack, pointers, banked data access and status flags
`timescale 1ns/1ps
module cpu_core_memory_addressing import core_addr_pkg::*; #(
   parameter bit large_variant = 1'b1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Sequencing from instruction decode
   input wire logic pc_step,
   input wire logic pc_jump,
   input wire logic pc_call,
   input wire logic pc_return,
   input wire logic irq_take,
   input wire logic [14:0] pc_target,
   output logic [14:0] pc,
   // Stack fault control
   input wire logic stack_reset_en,
   input wire logic clear_ovf,
   input wire logic clear_unf,
   output logic stack_overflow_flag,
   output logic stack_underflow_flag,
   output logic soft_reset,
   // File register access
   input wire file_req_t file_req,
   output logic file_busy,
   output logic file_done,
   output logic [7:0] file_rdata,
   // ALU flag update
   input wire alu_req_t alu_req,
   output logic [7:0] alu_result,
   // Watchdog and sleep events
   input wire logic watchdog_clear_instruction,
   input wire logic sleep_instruction,
   input wire logic wdt_timeout,
   // Program memory port
   output logic [14:0] pm_addr,
   output logic pm_rd,
   input wire logic [13:0] pm_rdata,
   // Banked data memory port
   output ram_req_t ram_req,
   input wire logic [7:0] ram_rdata,
   input wire logic ram_hit,
   // Core registers seen by the rest of the core
   output logic [7:0] working_accumulator,
   output logic [7:0] interrupt_control,
   output logic [7:0] alu_and_reset_flags
);

   typedef enum {st_idle, st_data, st_pm1, st_pm2} acc_state_t;

   function automatic logic [14:0] wrap(input logic [14:0] a);
      wrap = a & (large_variant ? PM_LAST_LARGE : PM_LAST_SMALL);
   endfunction : wrap

   function automatic logic is_indf(input logic [6:0] o);
      is_indf = (o == OFS_INDIRECT_DATA_PORT_0) || (o == OFS_INDIRECT_DATA_PORT_1);
   endfunction : is_indf

   function automatic alu_out_t alu_calc(input alu_req_t r, input logic cin);
      logic [8:0] s;
      logic [4:0] lo;
      alu_out_t q;
      s = 9'h000;
      lo = 5'h00;
      q = '0;
      unique case (r.op)
         alu_add: begin
            s = {1'b0, r.a} + {1'b0, r.b};
            lo = {1'b0, r.a[3:0]} + {1'b0, r.b[3:0]};
            q = {s[7:0], s[7:0] == 8'h00, lo[4], s[8], 3'b111};
         end
         alu_sub: begin
            // Add of two's complement, so carries are inverted borrows
            s = {1'b0, r.a} + {1'b0, ~r.b} + 9'h001;
            lo = {1'b0, r.a[3:0]} + {1'b0, ~r.b[3:0]} + 5'h01;
            q = {s[7:0], s[7:0] == 8'h00, lo[4], s[8], 3'b111};
         end
         alu_logic: q = {r.b, r.b == 8'h00, 1'b0, 1'b0, 3'b100};
         alu_rot_left: q = {r.a[6:0], cin, 1'b0, 1'b0, r.a[7], 3'b001};
         alu_rot_right: q = {cin, r.a[7:1], 1'b0, 1'b0, r.a[0], 3'b001};
      endcase
      alu_calc = q;
   endfunction : alu_calc

   // Core register state
   logic [15:0] ptr0;
   logic [15:0] ptr1;
   logic [7:0] bank_select;
   logic [7:0] counter_upper_latch;
   logic to_flag;
   logic pd_flag;
   logic z_flag;
   logic dc_flag;
   logic c_flag;
   // Stack
   logic [14:0] stack_mem [STACK_DEPTH];
   logic [4:0] stack_count;
   logic [4:0] stack_below;
   logic push_en;
   logic [14:0] push_val;
   logic stack_fault;
   // Access sequencer
   acc_state_t state;
   logic [15:0] sel_ptr;
   logic tgt_ind;
   logic tgt_pm;
   logic [11:0] tgt_addr;
   logic tgt_core;
   logic take_rd;
   logic take_wr;
   logic core_wr;
   logic [6:0] acc_ofs;
   logic acc_core;
   logic [14:0] acc_pm;
   logic [7:0] core_rd;
   alu_out_t alu_q;
   logic [7:0] w_reg_q;

   assign working_accumulator = w_reg_q;
   assign alu_and_reset_flags = {STATUS_PAD, to_flag, pd_flag, z_flag, dc_flag, c_flag};

   // Target resolution: direct uses bank select, indirect uses a pointer
   always_comb begin
      sel_ptr = (file_req.ofs == OFS_INDIRECT_DATA_PORT_0) ? ptr0 : ptr1;
      tgt_ind = is_indf(file_req.ofs);
      tgt_pm = tgt_ind & sel_ptr[PTR_PM_BIT];
      tgt_addr = tgt_ind ? sel_ptr[11:0] : {bank_select[4:0], file_req.ofs};
      tgt_core = tgt_addr[6:0] <= OFS_INTERRUPT_CONTROL;
   end

   assign file_busy = state != st_idle;
   assign take_rd = file_req.rd & (state == st_idle);
   assign take_wr = file_req.wr & ~file_req.rd & (state == st_idle);
   // Indirect writes aimed at program memory are dropped
   assign core_wr = take_wr & tgt_core & ~tgt_pm;

   always_comb begin
      ram_req = '0;
      ram_req.addr = tgt_addr;
      ram_req.wdata = file_req.wdata;
      ram_req.re = take_rd & ~tgt_core & ~tgt_pm;
      ram_req.we = take_wr & ~tgt_core & ~tgt_pm;
   end

   // Read sequencer; program memory reads take one extra cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= st_idle;
         acc_ofs <= 7'h00;
         acc_core <= 1'b0;
         acc_pm <= 15'h0000;
      end else begin
         unique case (state)
            st_idle: if (take_rd) begin
               acc_ofs <= tgt_addr[6:0];
               acc_core <= tgt_core;
               acc_pm <= wrap(sel_ptr[14:0]);
               state <= tgt_pm ? st_pm1 : st_data;
            end
            st_data: state <= st_idle;
            st_pm1: state <= st_pm2;
            st_pm2: state <= st_idle;
         endcase
      end
   end

   always_comb begin
      unique case (acc_ofs)
         OFS_PCL: core_rd = pc[7:0];
         OFS_STATUS: core_rd = alu_and_reset_flags;
         OFS_PTR0_LO: core_rd = ptr0[7:0];
         OFS_PTR0_HI: core_rd = ptr0[15:8];
         OFS_PTR1_LO: core_rd = ptr1[7:0];
         OFS_PTR1_HI: core_rd = ptr1[15:8];
         OFS_BSR: core_rd = bank_select;
         OFS_WORKING_ACCUMULATOR: core_rd = w_reg_q;
         OFS_COUNTER_UPPER_LATCH: core_rd = counter_upper_latch;
         OFS_INTERRUPT_CONTROL: core_rd = interrupt_control;
         default: core_rd = 8'h00;
      endcase
   end

   assign pm_rd = (state == st_pm1) | (state == st_pm2);
   assign pm_addr = pm_rd ? acc_pm : pc;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         file_done <= 1'b0;
         file_rdata <= 8'h00;
      end else begin
         file_done <= (state == st_data) | (state == st_pm2);
         if (state == st_data) begin
            if (acc_core) begin
               file_rdata <= core_rd;
            end else begin
               file_rdata <= ram_hit ? ram_rdata : 8'h00;
            end
         end else if (state == st_pm2) begin
            file_rdata <= pm_rdata[7:0];
         end
      end
   end

   // Pointers, bank select, accumulator, latch and interrupt control
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ptr0 <= {CORE_RST, CORE_RST};
         ptr1 <= {CORE_RST, CORE_RST};
         bank_select <= CORE_RST;
         w_reg_q <= CORE_RST;
         counter_upper_latch <= CORE_RST;
         interrupt_control <= CORE_RST;
      end else if (core_wr) begin
         unique case (tgt_addr[6:0])
            OFS_PTR0_LO: ptr0[7:0] <= file_req.wdata;
            OFS_PTR0_HI: ptr0[15:8] <= file_req.wdata;
            OFS_PTR1_LO: ptr1[7:0] <= file_req.wdata;
            OFS_PTR1_HI: ptr1[15:8] <= file_req.wdata;
            // Only 32 banks exist, upper bits are not stored
            OFS_BSR: bank_select <= {3'h0, file_req.wdata[4:0]};
            OFS_WORKING_ACCUMULATOR: w_reg_q <= file_req.wdata;
            OFS_COUNTER_UPPER_LATCH: counter_upper_latch <= {1'b0, file_req.wdata[6:0]};
            OFS_INTERRUPT_CONTROL: interrupt_control <= file_req.wdata;
            default: ;
         endcase
      end
   end

   // Status flags
   assign alu_q = alu_calc(alu_req, c_flag);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         to_flag <= 1'b1;
         pd_flag <= 1'b1;
         z_flag <= 1'b0;
         dc_flag <= 1'b0;
         c_flag <= 1'b0;
         alu_result <= 8'h00;
      end else begin
         if (wdt_timeout) begin
            to_flag <= 1'b0;
         end else if (watchdog_clear_instruction | sleep_instruction) begin
            to_flag <= 1'b1;
         end
         if (watchdog_clear_instruction) begin
            pd_flag <= 1'b1;
         end else if (sleep_instruction) begin
            pd_flag <= 1'b0;
         end
         if (alu_req.go) begin
            // A flag-affecting op blocks the whole status file write, even for bits its mask leaves unchanged
            alu_result <= alu_q.res;
            if (alu_q.mz) z_flag <= alu_q.z;
            if (alu_q.mdc) dc_flag <= alu_q.dc;
            if (alu_q.mc) c_flag <= alu_q.c;
         end else if (core_wr && tgt_addr[6:0] == OFS_STATUS) begin
            z_flag <= file_req.wdata[ST_Z];
            dc_flag <= file_req.wdata[ST_DC];
            c_flag <= file_req.wdata[ST_C];
         end
      end
   end

   // Return stack
   assign push_en = pc_call | irq_take;
   assign push_val = irq_take ? pc : wrap(pc + 15'h0001);
   assign stack_below = stack_count - 5'h01;
   assign stack_fault = (push_en & (stack_count == STACK_FULL))
      | (pc_return & ~push_en & (stack_count == 5'h00));

   always_ff @(posedge clk) begin
      if (push_en && stack_count != STACK_FULL) begin
         stack_mem[stack_count[3:0]] <= push_val;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stack_overflow_flag <= 1'b0;
         stack_underflow_flag <= 1'b0;
         soft_reset <= 1'b0;
      end else begin
         // A fault in the clearing cycle still sets the flag
         if (push_en && stack_count == STACK_FULL) begin
            stack_overflow_flag <= 1'b1;
         end else if (clear_ovf) begin
            stack_overflow_flag <= 1'b0;
         end
         if (pc_return && !push_en && stack_count == 5'h00) begin
            stack_underflow_flag <= 1'b1;
         end else if (clear_unf) begin
            stack_underflow_flag <= 1'b0;
         end
         soft_reset <= stack_fault & stack_reset_en;
      end
   end

   // Program counter and stack pointer
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pc <= RESET_VECTOR;
         stack_count <= 5'h00;
      end else if (soft_reset) begin
         pc <= RESET_VECTOR;
         stack_count <= 5'h00;
      end else if (push_en) begin
         if (stack_count != STACK_FULL) begin
            stack_count <= stack_count + 5'h01;
         end
         pc <= irq_take ? IRQ_VECTOR : wrap(pc_target);
      end else if (pc_return) begin
         if (stack_count != 5'h00) begin
            stack_count <= stack_below;
            pc <= stack_mem[stack_below[3:0]];
         end
      end else if (pc_jump) begin
         pc <= wrap(pc_target);
      end else if (core_wr && tgt_addr[6:0] == OFS_PCL) begin
         pc <= wrap({counter_upper_latch[6:0], file_req.wdata});
      end else if (pc_step) begin
         pc <= wrap(pc + 15'h0001);
      end
   end

endmodule : cpu_core_memory_addressing

// file: cpu_core_memory_addressing_assertions.sv
// Port-level assertions for the core addressing block
`timescale 1ns/1ps
module cpu_core_memory_addressing_assertions import core_addr_pkg::*; #(
   parameter bit large_variant = 1'b1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Sequencing and stack
   input wire logic pc_jump,
   input wire logic pc_call,
   input wire logic pc_return,
   input wire logic irq_take,
   input wire logic [14:0] pc_target,
   input wire logic [14:0] pc,
   input wire logic stack_reset_en,
   input wire logic stack_overflow_flag,
   input wire logic soft_reset,
   // File and ALU
   input wire file_req_t file_req,
   input wire logic file_busy,
   input wire logic file_done,
   input wire logic [7:0] file_rdata,
   input wire alu_req_t alu_req,
   input wire logic [7:0] alu_result,
   input wire logic [7:0] alu_and_reset_flags,
   // Events and memories
   input wire logic sleep_instruction,
   input wire logic wdt_timeout,
   input wire logic pm_rd,
   input wire logic [13:0] pm_rdata,
   input wire ram_req_t ram_req,
   input wire logic ram_hit
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   logic [7:0] pm_low;
   logic [7:0] a_q;
   logic [7:0] b_q;
   logic [14:0] mask;
   logic data_take;
   assign mask = large_variant ? PM_LAST_LARGE : PM_LAST_SMALL;
   assign data_take = file_req.rd && !file_busy && file_req.ofs > OFS_INTERRUPT_CONTROL;
   always_ff @(posedge clk) begin
      pm_low <= pm_rdata[7:0];
      a_q <= alu_req.a;
      b_q <= alu_req.b;
   end
   AST_PAD: assert property (alu_and_reset_flags[7:5] == STATUS_PAD)
      else $error("Upper flag bits not zero");
   AST_RESET_VEC: assert property ($rose(rstn) |-> pc == RESET_VECTOR)
      else $error("Counter not at reset vector");
   AST_JUMP_WRAP: assert property (pc_jump && !(pc_call || pc_return || irq_take || soft_reset)
      |=> pc == ($past(pc_target) & mask)) else $error("Jump did not wrap");
   AST_PM_EXTRA: assert property ($rose(pm_rd) |-> pm_rd [*2] ##1 (file_done && !pm_rd))
      else $error("Program read length wrong");
   AST_PM_LOW: assert property (pm_rd ##1 pm_rd |=> file_rdata == pm_low)
      else $error("Program read data wrong");
   AST_DATA_READ: assert property (data_take |-> ram_req.re && ram_req.addr[6:0] == file_req.ofs
      ##2 file_done) else $error("Data read wrong");
   AST_UNMAPPED: assert property (data_take ##1 !ram_hit |=> file_rdata == 8'h00)
      else $error("Unmapped read not zero");
   AST_FAULT_RST: assert property ($rose(stack_overflow_flag) && stack_reset_en
      |-> ##[0:1] soft_reset) else $error("No reset on overflow");
   AST_SOFT_PC: assert property (soft_reset |=> pc == RESET_VECTOR)
      else $error("Soft reset left counter");
   AST_TIMEOUT: assert property (wdt_timeout |=> !alu_and_reset_flags[ST_TO])
      else $error("Time-out flag not cleared");
   AST_SLEEP: assert property (sleep_instruction && !wdt_timeout |=> alu_and_reset_flags[ST_TO]
      && !alu_and_reset_flags[ST_PD]) else $error("Sleep flags wrong");
   AST_ADD: assert property (alu_req.go && alu_req.op == alu_add |=> {alu_and_reset_flags[ST_C],
      alu_result} == {1'b0, a_q} + {1'b0, b_q}) else $error("Add result wrong");
   cover property (pm_rd ##1 pm_rd ##1 file_done);
   cover property (soft_reset);
   cover property (data_take ##1 !ram_hit);
endmodule : cpu_core_memory_addressing_assertions

bind cpu_core_memory_addressing cpu_core_memory_addressing_assertions #(
   .large_variant(large_variant)) i_chk (.clk(clk), .rstn(rstn), .pc_jump(pc_jump),
   .pc_call(pc_call), .pc_return(pc_return), .irq_take(irq_take), .pc_target(pc_target),
   .pc(pc), .stack_reset_en(stack_reset_en), .stack_overflow_flag(stack_overflow_flag),
   .soft_reset(soft_reset), .file_req(file_req), .file_busy(file_busy),
   .file_done(file_done), .file_rdata(file_rdata), .alu_req(alu_req),
   .alu_result(alu_result), .alu_and_reset_flags(alu_and_reset_flags),
   .sleep_instruction(sleep_instruction), .wdt_timeout(wdt_timeout), .pm_rd(pm_rd),
   .pm_rdata(pm_rdata), .ram_req(ram_req), .ram_hit(ram_hit));

// file: mem_model.sv
// Behavioural program flash and banked data RAM
`timescale 1ns/1ps
module mem_model import core_addr_pkg::*; (
   // Clock
   input wire logic clk,
   // Program memory
   input wire logic [14:0] pm_addr,
   input wire logic pm_rd,
   output logic [13:0] pm_rdata,
   // Data memory
   input wire ram_req_t ram_req,
   output logic [7:0] ram_rdata,
   output logic ram_hit
);
   logic [7:0] mem [BANKS * BANK_BYTES];
   logic [13:0] word;
   // Fixed pattern stands in for flash; no write path at all
   assign word = pm_addr[13:0] ^ 14'h15A5;
   // Idle bus shows the inverse so stale data never matches
   assign pm_rdata = pm_rd ? word : ~word;
   initial begin
      foreach (mem[i]) mem[i] = 8'h00;
   end
   always @(posedge clk) begin
      if (ram_req.we) begin
         mem[ram_req.addr] <= ram_req.wdata;
      end
      // Only general and common RAM exist, peripheral slots do not
      ram_hit <= ram_req.re && ram_req.addr[6:0] >= 7'h20;
      ram_rdata <= ram_req.re ? mem[ram_req.addr] : ~ram_rdata;
   end
endmodule : mem_model

// file: tb.sv
// Self-checking bench for the core addressing block
`timescale 1ns/1ps
module tb;
   import core_addr_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic sre = 1'b0;
   logic [9:0] ctl = '0;
   logic [14:0] tgt = '0;
   file_req_t freq = '0;
   alu_req_t areq = '0;
   logic [14:0] pc, pm_addr;
   logic ovf, unf, srst, busy, done, pm_rd, ram_hit;
   logic [7:0] rdata, ares, stat, ram_rdata, v, a, b, wacc, ictl;
   logic [13:0] pm_rdata;
   ram_req_t rreq, lastw;
   logic [8:0] s;
   logic [4:0] d;
   alu_op_t op;
   logic [7:0] expq [$];
   logic [9:0] evs [3] = '{10'h040, 10'h080, 10'h020};
   logic [1:0] evx [3] = '{2'b10, 2'b00, 2'b11};
   integer seed = 32'h44BAEA33;
   int failures = 0;
   int n_tests = 0;
   always #20 clk = ~clk;
   cpu_core_memory_addressing #(.large_variant(1'b1)) i_dut (
      .clk(clk), .rstn(rstn), .pc_step(ctl[0]), .pc_jump(ctl[1]), .pc_call(ctl[2]),
      .pc_return(ctl[3]), .irq_take(ctl[4]), .pc_target(tgt), .pc(pc),
      .stack_reset_en(sre), .clear_ovf(ctl[8]), .clear_unf(ctl[9]),
      .stack_overflow_flag(ovf), .stack_underflow_flag(unf), .soft_reset(srst),
      .file_req(freq), .file_busy(busy), .file_done(done), .file_rdata(rdata),
      .alu_req(areq), .alu_result(ares), .watchdog_clear_instruction(ctl[5]),
      .sleep_instruction(ctl[6]), .wdt_timeout(ctl[7]), .pm_addr(pm_addr), .pm_rd(pm_rd),
      .pm_rdata(pm_rdata), .ram_req(rreq), .ram_rdata(ram_rdata), .ram_hit(ram_hit),
      .working_accumulator(wacc), .interrupt_control(ictl), .alu_and_reset_flags(stat));
   mem_model i_mem (.clk(clk), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_rdata(pm_rdata),
      .ram_req(rreq), .ram_rdata(ram_rdata), .ram_hit(ram_hit));
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_of_test
   task automatic act(input logic [9:0] c, input logic [14:0] t);
      @(posedge clk);
      ctl <= c;
      tgt <= t;
      @(posedge clk);
      ctl <= '0;
      @(negedge clk);
   endtask : act
   task automatic wr(input logic [6:0] o, input logic [7:0] x);
      @(posedge clk);
      freq <= '{1'b0, 1'b1, o, x};
      @(negedge clk);
      lastw = rreq;
      @(posedge clk);
      freq <= '0;
   endtask : wr
   // Fixed wait covers the longest answer, three cycles for program reads
   task automatic rd(input logic [6:0] o, input logic [7:0] e);
      @(posedge clk);
      freq <= '{1'b1, 1'b0, o, 8'h00};
      expq.push_back(e);
      @(posedge clk);
      freq <= '0;
      repeat (3) @(posedge clk);
   endtask : rd
   task automatic alu(input alu_op_t o, input logic [7:0] x, input logic [7:0] y);
      @(posedge clk);
      areq <= '{1'b1, o, x, y};
      @(posedge clk);
      areq.go <= 1'b0;
      @(negedge clk);
   endtask : alu
   always @(negedge clk) begin
      if (done === 1'b1) begin
         chk(rdata, expq.size() > 0 ? expq.pop_front() : 8'hXX);
      end
   end
   initial begin
      #100000;
      failures++;
      end_of_test();
   end
   initial begin
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      for (int i = 0; i < 12; i++) rd(7'(i), (i == 3) ? 8'h18 : 8'h00);
      v = 8'($random(seed));
      wr(OFS_BSR, 8'h02);
      wr(7'h25, v);
      chk(lastw, {1'b0, 1'b1, 12'h125, v});
      rd(7'h25, v);
      rd(7'h15, 8'h00);
      wr(OFS_BSR, 8'h05);
      rd(7'h25, 8'h00);
      rd(OFS_BSR, 8'h05);
      wr(OFS_WORKING_ACCUMULATOR, v);
      wr(OFS_INTERRUPT_CONTROL, ~v);
      @(negedge clk);
      chk({wacc, ictl}, {v, ~v});
      wr(OFS_PTR0_LO, 8'h25);
      wr(OFS_PTR0_HI, 8'h01);
      rd(OFS_INDIRECT_DATA_PORT_0, v);
      wr(OFS_PTR1_LO, v);
      wr(OFS_PTR1_HI, 8'h81);
      rd(OFS_INDIRECT_DATA_PORT_1, v ^ 8'hA5);
      rd(OFS_INDIRECT_DATA_PORT_1, v ^ 8'hA5);
      wr(OFS_INDIRECT_DATA_PORT_1, 8'h3C);
      chk(lastw.we, 1'b0);
      @(posedge clk);
      freq <= '{1'b0, 1'b1, OFS_STATUS, 8'hFF};
      areq <= '{1'b1, alu_add, 8'h01, 8'h01};
      @(posedge clk);
      freq <= '0;
      areq.go <= 1'b0;
      @(negedge clk);
      chk(stat, 8'h18);
      for (int i = 0; i < 8; i++) begin
         a = 8'($random(seed));
         b = (i == 1) ? a : 8'($random(seed));
         op = (i % 2) ? alu_sub : alu_add;
         alu(op, a, b);
         s = (op == alu_sub) ? {1'b0, a} + {1'b0, ~b} + 9'h001 : {1'b0, a} + {1'b0, b};
         d = (op == alu_sub) ? {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01
            : {1'b0, a[3:0]} + {1'b0, b[3:0]};
         chk({ares, stat[2:0]}, {s[7:0], s[7:0] == 8'h00, d[4], s[8]});
      end
      alu(alu_rot_left, v, 8'h00);
      chk(stat[ST_C], v[7]);
      alu(alu_rot_right, v, 8'h00);
      chk(stat[ST_C], v[0]);
      for (int i = 0; i < 3; i++) begin
         act(evs[i], 15'h0000);
         chk(stat[4:3], evx[i]);
      end
      act(10'h002, 15'h7FFF);
      chk(pc, 15'h3FFF);
      act(10'h001, 15'h0000);
      chk(pc, 15'h0000);
      act(10'h002, 15'h0100);
      act(10'h004, 15'h0200);
      chk(pc, 15'h0200);
      act(10'h008, 15'h0000);
      chk(pc, 15'h0101);
      act(10'h010, 15'h0000);
      chk(pc, IRQ_VECTOR);
      act(10'h008, 15'h0000);
      chk(pc, 15'h0101);
      sre <= 1'b1;
      for (int i = 0; i < 17; i++) begin
         if (i == 16) chk(ovf, 1'b0);
         act(10'h004, 15'(i + 8));
      end
      repeat (2) @(negedge clk);
      chk({ovf, unf, pc}, {2'b10, 15'h0000});
      act(10'h008, 15'h0000);
      repeat (2) @(negedge clk);
      chk({ovf, unf, pc}, {2'b11, 15'h0000});
      act(10'h300, 15'h0000);
      chk({ovf, unf}, 2'b00);
      chk(expq.size(), 0);
      end_of_test();
   end
endmodule : tb
